/* ulp_regs_pkg.sv */
package ulp_regs_pkg;

  // Register offsets on the link register port
  localparam logic [7:0] ULP_ADDR_EVENT_LATCH = 8'h14;
  localparam logic [7:0] ULP_ADDR_LINE_DEBUG  = 8'h15;
  localparam logic [7:0] ULP_ADDR_SCRATCH     = 8'h16;
  localparam logic [7:0] ULP_ADDR_SCRATCH_SET = 8'h17;
  localparam logic [7:0] ULP_ADDR_SCRATCH_CLR = 8'h18;
  localparam logic [7:0] ULP_ADDR_POWER_CTRL  = 8'h3d;

  localparam logic [7:0] ULP_RESET_BYTE = 8'h00;

  // Event latch bit positions
  localparam int ULP_EV_W    = 5;
  localparam int ULP_EV_ID   = 4;
  localparam int ULP_EV_SEND = 3;
  localparam int ULP_EV_SVLD = 2;
  localparam int ULP_EV_VBUS = 1;
  localparam int ULP_EV_RDET = 0;

  // Charger power control bit positions
  localparam int ULP_PC_FOUND  = 7;
  localparam int ULP_PC_SENSE  = 6;
  localparam int ULP_PC_DMREF  = 5;
  localparam int ULP_PC_WKPU   = 4;
  localparam int ULP_PC_DROP   = 3;
  localparam int ULP_PC_RISE   = 2;
  localparam int ULP_PC_DONE   = 1;
  localparam int ULP_PC_MANUAL = 0;

  // Layout of the synchronised pin vector
  localparam int ULP_SI_EV    = 0;
  localparam int ULP_SI_BVLD  = 5;
  localparam int ULP_SI_DMREF = 6;
  localparam int ULP_SI_FOUND = 7;
  localparam int ULP_SI_SENSE = 8;
  localparam int ULP_SI_LINE  = 9;
  localparam int ULP_SI_W     = 11;

  // Timing
  localparam int ULP_CLK_HZ       = 25_000_000;
  localparam int ULP_ID_MASK_MS   = 50;
  localparam int ULP_ID_MASK_CYC  = ULP_ID_MASK_MS * (ULP_CLK_HZ / 1000);
  localparam int ULP_ID_CNT_W     = 21;
  localparam logic [1:0] ULP_FILL_CYC = 2'h2;

  typedef enum logic [1:0] {
    ULP_INIT_FILL,
    ULP_INIT_SEED,
    ULP_INIT_RUN
  } ulp_init_t;

endpackage

/* ulp_event_regs.sv */
`timescale 1ns/1ps
module ulp_event_regs
  import ulp_regs_pkg::*;
#(
  parameter int unsigned ID_MASK_CYCLES = ULP_ID_MASK_CYC
) (
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_rvalid,
  input  wire logic                id_grounded,
  input  wire logic                session_ended,
  input  wire logic                session_valid,
  input  wire logic                bus_power_valid,
  input  wire logic                remote_detached,
  input  wire logic                b_session_valid,
  input  wire logic                dminus_above_ref,
  input  wire logic                hw_charger_found,
  input  wire logic                hw_sense_source,
  input  wire logic [1:0]          bus_line_levels,
  input  wire logic [ULP_EV_W-1:0] int_en_rise,
  input  wire logic [ULP_EV_W-1:0] int_en_fall,
  input  wire logic                id_pullup_enable,
  input  wire logic                low_power_enter,
  input  wire logic                serial_mode_enter,
  input  wire logic                carkit_mode_enter,
  input  wire logic                sync_mode,
  input  wire logic                charger_pin_polarity,
  output logic                     charger_indicate_pin_o,
  output logic                     charger_indicate_pin_oe,
  output logic                     dplus_sense_source_en,
  output logic                     dplus_weak_pullup_en,
  output logic                     alt_event_flag,
  output logic                     charger_fsm_idle
);

  logic [ULP_SI_W-1:0]     pin_meta_q;
  logic [ULP_SI_W-1:0]     pin_q;
  ulp_init_t               init_q;
  logic [1:0]              fill_q;
  logic [ULP_EV_W-1:0]     prev_q;
  logic [ULP_EV_W-1:0]     latch_q;
  logic [ULP_ID_CNT_W-1:0] id_cnt_q;
  logic [7:0]              scratch_q;
  logic                    manual_q;
  logic                    found_q;
  logic                    sense_q;
  logic                    wkpu_q;
  logic                    drop_q;
  logic                    rise_q;
  logic                    bvld_prev_q;
  logic [7:0]              rdata_q;
  logic                    rvalid_q;
  logic                    alt_q;
  logic                    fsm_idle_q;
  logic                    chg_oe_q;
  logic                    sense_en_q;
  logic                    wkpu_en_q;

  logic                    run;
  logic [ULP_EV_W-1:0]     cur;
  logic [ULP_EV_W-1:0]     ev_mask;
  logic [ULP_EV_W-1:0]     ev_set;
  logic                    id_settled;
  logic                    rd_latch;
  logic                    mode_clr;
  logic                    pc_wr;
  logic                    takeover;
  logic                    bvld;
  logic [7:0]              pc_view;

  default clocking ulp_cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  function automatic logic [7:0] apply_bits(input logic [7:0] old,
                                            input logic [7:0] mask,
                                            input logic       set);
    apply_bits = set ? (old | mask) : (old & ~mask);
  endfunction

  function automatic logic is_addr(input logic [7:0] a,
                                   input logic [7:0] b);
    is_addr = (a == b);
  endfunction

  // Analogue status pins are asynchronous to the link clock
  always_ff @(posedge clk_sys) begin
    pin_meta_q <= {bus_line_levels, hw_sense_source, hw_charger_found,
                   dminus_above_ref, b_session_valid, id_grounded,
                   session_ended, session_valid, bus_power_valid,
                   remote_detached};
    pin_q      <= pin_meta_q;
  end

  assign cur  = pin_q[ULP_SI_EV +: ULP_EV_W];
  assign bvld = pin_q[ULP_SI_BVLD];
  assign run  = (init_q == ULP_INIT_RUN);

  // Wait for the synchronisers to fill before seeding edge history
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      init_q <= ULP_INIT_FILL;
      fill_q <= 2'h0;
    end else begin
      case (init_q)
        ULP_INIT_FILL: begin
          fill_q <= fill_q + 2'h1;
          if (fill_q == ULP_FILL_CYC) begin
            init_q <= ULP_INIT_SEED;
          end
        end
        ULP_INIT_SEED: init_q <= ULP_INIT_RUN;
        ULP_INIT_RUN:  init_q <= ULP_INIT_RUN;
        default:       init_q <= ULP_INIT_FILL;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      id_cnt_q <= '0;
    end else if (!id_pullup_enable) begin
      id_cnt_q <= '0;
    end else if (!id_settled) begin
      id_cnt_q <= id_cnt_q + ULP_ID_CNT_W'(1);
    end
  end

  assign id_settled = id_pullup_enable &&
                      (32'(id_cnt_q) >= ID_MASK_CYCLES);

  always_comb begin
    ev_mask = '1;
    ev_mask[ULP_EV_ID] = id_settled;
  end

  // Edge detect gated by the per-edge enables
  assign ev_set = ((cur & ~prev_q & int_en_rise) |
                   (~cur & prev_q & int_en_fall)) &
                  ev_mask & {ULP_EV_W{run}};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prev_q <= '0;
    end else begin
      prev_q <= cur;
    end
  end

  assign rd_latch = reg_rd && is_addr(reg_addr, ULP_ADDR_EVENT_LATCH);
  assign mode_clr = low_power_enter | serial_mode_enter | carkit_mode_enter;

  // A mode-entry clear still keeps an event of the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      latch_q <= '0;
    end else if (init_q == ULP_INIT_SEED) begin
      latch_q <= '0;
      latch_q[ULP_EV_RDET] <= cur[ULP_EV_RDET];
    end else if (rd_latch) begin
      latch_q <= '0;
    end else if (mode_clr) begin
      latch_q <= ev_set;
    end else begin
      latch_q <= latch_q | ev_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scratch_q <= ULP_RESET_BYTE;
    end else if (reg_wr && is_addr(reg_addr, ULP_ADDR_SCRATCH)) begin
      scratch_q <= reg_wdata;
    end else if (reg_wr && is_addr(reg_addr, ULP_ADDR_SCRATCH_SET)) begin
      scratch_q <= apply_bits(scratch_q, reg_wdata, 1'b1);
    end else if (reg_wr && is_addr(reg_addr, ULP_ADDR_SCRATCH_CLR)) begin
      scratch_q <= apply_bits(scratch_q, reg_wdata, 1'b0);
    end
  end

  assign pc_wr    = reg_wr && is_addr(reg_addr, ULP_ADDR_POWER_CTRL);
  assign takeover = pc_wr && !manual_q && reg_wdata[ULP_PC_MANUAL];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      manual_q <= 1'b0;
      wkpu_q   <= 1'b0;
      drop_q   <= 1'b0;
      rise_q   <= 1'b0;
    end else if (pc_wr) begin
      manual_q <= reg_wdata[ULP_PC_MANUAL];
      wkpu_q   <= reg_wdata[ULP_PC_WKPU];
      drop_q   <= reg_wdata[ULP_PC_DROP];
      rise_q   <= reg_wdata[ULP_PC_RISE];
    end
  end

  // Found and sense bits only take write data once already manual
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      found_q <= 1'b0;
      sense_q <= 1'b0;
    end else if (pc_wr && manual_q) begin
      found_q <= reg_wdata[ULP_PC_FOUND];
      sense_q <= reg_wdata[ULP_PC_SENSE];
    end else if (!manual_q) begin
      found_q <= pin_q[ULP_SI_FOUND];
      sense_q <= pin_q[ULP_SI_SENSE];
    end
  end

  always_comb begin
    pc_view                = 8'h00;
    pc_view[ULP_PC_FOUND]  = found_q;
    pc_view[ULP_PC_SENSE]  = sense_q;
    pc_view[ULP_PC_DMREF]  = pin_q[ULP_SI_DMREF];
    pc_view[ULP_PC_WKPU]   = wkpu_q;
    pc_view[ULP_PC_DROP]   = drop_q;
    pc_view[ULP_PC_RISE]   = rise_q;
    pc_view[ULP_PC_DONE]   = found_q & ~manual_q;
    pc_view[ULP_PC_MANUAL] = manual_q;
  end

  // Register read path, one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          ULP_ADDR_EVENT_LATCH:
            rdata_q <= 8'(latch_q | ev_set);
          ULP_ADDR_LINE_DEBUG:
            rdata_q <= 8'(pin_q[ULP_SI_LINE +: 2]);
          ULP_ADDR_SCRATCH, ULP_ADDR_SCRATCH_SET, ULP_ADDR_SCRATCH_CLR:
            rdata_q <= scratch_q;
          ULP_ADDR_POWER_CTRL:
            rdata_q <= pc_view;
          default:
            rdata_q <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bvld_prev_q <= 1'b0;
      alt_q       <= 1'b0;
    end else begin
      bvld_prev_q <= bvld;
      alt_q       <= run &&
                     ((drop_q && bvld_prev_q && !bvld) ||
                      (rise_q && !bvld_prev_q && bvld));
    end
  end

  // Sense source kept at its captured level, so dead-battery
  // detection stays enabled across the hand-over
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fsm_idle_q <= 1'b0;
      chg_oe_q   <= 1'b0;
      sense_en_q <= 1'b0;
      wkpu_en_q  <= 1'b0;
    end else begin
      fsm_idle_q <= takeover;
      chg_oe_q   <= manual_q ? found_q
                             : pin_q[ULP_SI_FOUND];
      sense_en_q <= manual_q ? sense_q : pin_q[ULP_SI_SENSE];
      wkpu_en_q  <= wkpu_q && sync_mode &&
                    cur[ULP_EV_SVLD];
    end
  end

  assign reg_rdata               = rdata_q;
  assign reg_rvalid              = rvalid_q;
  assign alt_event_flag          = alt_q;
  assign charger_fsm_idle        = fsm_idle_q;
  assign charger_indicate_pin_oe = chg_oe_q;
  assign charger_indicate_pin_o  = charger_pin_polarity;
  assign dplus_sense_source_en   = sense_en_q;
  assign dplus_weak_pullup_en    = wkpu_en_q;

  latch_set_a: assert property (
    (ev_set[ULP_EV_SEND] && !rd_latch) |=> latch_q[ULP_EV_SEND])
    else $error("unmasked event not latched");
  read_clear_a: assert property (
    (rd_latch && run) |=> (latch_q == '0))
    else $error("latch not cleared by read");
  mode_clear_a: assert property (
    (mode_clr && !rd_latch && run) |=> (latch_q == $past(ev_set)))
    else $error("latch not cleared on mode entry");
  read_merge_a: assert property (
    rd_latch |=> (reg_rvalid &&
                  reg_rdata == 8'($past(latch_q) | $past(ev_set))))
    else $error("latch read lost a same-cycle event");
  scratch_set_a: assert property (
    (reg_wr && reg_addr == ULP_ADDR_SCRATCH_SET)
      |=> scratch_q == ($past(scratch_q) | $past(reg_wdata)))
    else $error("scratch set alias wrong");
  scratch_clr_a: assert property (
    (reg_wr && reg_addr == ULP_ADDR_SCRATCH_CLR)
      |=> scratch_q == ($past(scratch_q) & ~$past(reg_wdata)))
    else $error("scratch clear alias wrong");
  id_mask_a: assert property (
    !id_pullup_enable |-> !ev_set[ULP_EV_ID] ##1 (id_cnt_q == '0))
    else $error("id mask not restarted while pull-up off");
  takeover_a: assert property (
    takeover |=> (manual_q && charger_fsm_idle &&
                  found_q == $past(pin_q[ULP_SI_FOUND])))
    else $error("takeover context not captured");
  auto_pin_a: assert property (
    (!manual_q ##1 !manual_q) |->
      charger_indicate_pin_oe == $past(pin_q[ULP_SI_FOUND]))
    else $error("indicator pin not following detection");
  done_zero_a: assert property (
    manual_q |-> !pc_view[ULP_PC_DONE])
    else $error("detect done set in manual mode");
  notify_drop_a: assert property (
    (run && drop_q && bvld_prev_q && !bvld) |=> alt_event_flag)
    else $error("no alternate event on session drop");

endmodule

/* ulp_link_model.sv */
`timescale 1ns/1ps
// Link controller side of the register port, one access per call
module ulp_link_model (
  input  wire logic       clk_sys,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  // Latch is read only on request
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule

/* ulp_event_regs_tb_top.sv */
`timescale 1ns/1ps
module ulp_event_regs_tb_top;
  import ulp_regs_pkg::*;
  localparam int MASK_CYC = 20;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic       reg_wr, reg_rd, reg_rvalid, ok;
  logic [4:0] st = 5'h01;
  logic [4:0] en_r = 5'h1f;
  logic [4:0] en_f = 5'h1f;
  logic [1:0] line = 2'h0;
  logic       b_sess = 1'h0, dm_ref = 1'h0, hw_found = 1'h0;
  logic       hw_sense = 1'h0, id_pu = 1'h0, lp = 1'h0, ser = 1'h0;
  logic       car = 1'h0, sync_m = 1'h1, pol = 1'h1;
  logic       pin_o, pin_oe, sense_en, wkpu_en, alt_ev, fsm_idle;
  int         errors = 0;
  int         checked = 0;
  int         alt_cnt = 0;
  int         idle_cnt = 0;

  always #20 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (alt_ev === 1'b1) alt_cnt++;
    if (fsm_idle === 1'b1) idle_cnt++;
  end

  ulp_event_regs #(.ID_MASK_CYCLES(MASK_CYC)) ulp_event_regs_inst (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .id_grounded(st[4]), .session_ended(st[3]), .session_valid(st[2]),
    .bus_power_valid(st[1]), .remote_detached(st[0]),
    .b_session_valid(b_sess), .dminus_above_ref(dm_ref),
    .hw_charger_found(hw_found), .hw_sense_source(hw_sense),
    .bus_line_levels(line), .int_en_rise(en_r), .int_en_fall(en_f),
    .id_pullup_enable(id_pu), .low_power_enter(lp),
    .serial_mode_enter(ser), .carkit_mode_enter(car),
    .sync_mode(sync_m), .charger_pin_polarity(pol),
    .charger_indicate_pin_o(pin_o), .charger_indicate_pin_oe(pin_oe),
    .dplus_sense_source_en(sense_en), .dplus_weak_pullup_en(wkpu_en),
    .alt_event_flag(alt_ev), .charger_fsm_idle(fsm_idle));

  ulp_link_model ulp_link_model_inst (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  task automatic final_report;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e,
                      input string n);
    ulp_link_model_inst.rd(a, rv, ok);
    chk1("rvalid", 1'b1, ok);
    chk8(n, e, rv);
  endtask

  task automatic t_reset;
    rchk(ULP_ADDR_EVENT_LATCH, 8'h01, "latch_rst");
    rchk(ULP_ADDR_EVENT_LATCH, 8'h00, "latch_rc");
    rchk(ULP_ADDR_SCRATCH, 8'h00, "scr_rst");
    rchk(ULP_ADDR_POWER_CTRL, 8'h00, "pc_rst");
    rchk(8'h20, 8'h00, "unmapped");
  endtask

  task automatic t_line;
    for (int i = 0; i < 4; i++) begin
      line = i[1:0];
      cyc(4);
      rchk(ULP_ADDR_LINE_DEBUG, {6'h00, i[1:0]}, "line");
    end
    ulp_link_model_inst.wr(ULP_ADDR_LINE_DEBUG, 8'h00);
    rchk(ULP_ADDR_LINE_DEBUG, 8'h03, "line_ro");
  endtask

  task automatic t_scratch;
    ulp_link_model_inst.wr(ULP_ADDR_SCRATCH, 8'ha5);
    rchk(ULP_ADDR_SCRATCH, 8'ha5, "scr");
    ulp_link_model_inst.wr(ULP_ADDR_SCRATCH_SET, 8'h0f);
    rchk(ULP_ADDR_SCRATCH_SET, 8'haf, "scr_set");
    ulp_link_model_inst.wr(ULP_ADDR_SCRATCH_CLR, 8'ha0);
    rchk(ULP_ADDR_SCRATCH_CLR, 8'h0f, "scr_clr");
    ulp_link_model_inst.wr(ULP_ADDR_EVENT_LATCH, 8'hff);
    rchk(ULP_ADDR_EVENT_LATCH, 8'h00, "latch_ro");
  endtask

  task automatic t_events;
    st[ULP_EV_SVLD] = 1'b1;
    cyc(6);
    rchk(ULP_ADDR_EVENT_LATCH, 8'h04, "ev_rise");
    rchk(ULP_ADDR_EVENT_LATCH, 8'h00, "ev_rc");
    st[ULP_EV_SVLD] = 1'b0;
    cyc(6);
    rchk(ULP_ADDR_EVENT_LATCH, 8'h04, "ev_fall");
    en_r[ULP_EV_VBUS] = 1'b0;
    st[ULP_EV_VBUS] = 1'b1;
    cyc(6);
    rchk(ULP_ADDR_EVENT_LATCH, 8'h00, "ev_masked");
    en_r = 5'h1f;
    st[ULP_EV_VBUS] = 1'b0;
    st[ULP_EV_RDET] = 1'b0;
    cyc(6);
    rchk(ULP_ADDR_EVENT_LATCH, 8'h03, "ev_map");
    st[ULP_EV_SEND] = 1'b1;
    cyc(6);
    lp = 1'b1;
    cyc(1);
    lp = 1'b0;
    cyc(2);
    rchk(ULP_ADDR_EVENT_LATCH, 8'h00, "ev_lowpow");
    for (int k = 0; k < 2; k++) begin
      st[ULP_EV_SEND] = ~st[ULP_EV_SEND];
      cyc(6);
      ser = (k == 0);
      car = (k == 1);
      cyc(1);
      ser = 1'b0;
      car = 1'b0;
      cyc(2);
      rchk(ULP_ADDR_EVENT_LATCH, 8'h00, "ev_mode");
    end
  endtask

  task automatic t_id;
    st[ULP_EV_ID] = 1'b1;
    cyc(6);
    rchk(ULP_ADDR_EVENT_LATCH, 8'h00, "id_nopu");
    id_pu = 1'b1;
    cyc(MASK_CYC / 2);
    st[ULP_EV_ID] = 1'b0;
    cyc(6);
    rchk(ULP_ADDR_EVENT_LATCH, 8'h00, "id_settle");
    cyc(MASK_CYC);
    st[ULP_EV_ID] = 1'b1;
    cyc(6);
    rchk(ULP_ADDR_EVENT_LATCH, 8'h10, "id_event");
  endtask

  task automatic t_charger;
    hw_found = 1'b1;
    hw_sense = 1'b1;
    dm_ref = 1'b1;
    cyc(6);
    rchk(ULP_ADDR_POWER_CTRL, 8'he2, "pc_auto");
    chk1("oe_auto", 1'b1, pin_oe);
    chk1("pin_auto", pol, pin_o);
    hw_found = 1'b0;
    cyc(6);
    chk1("oe_auto0", 1'b0, pin_oe);
    ulp_link_model_inst.wr(ULP_ADDR_POWER_CTRL, 8'hc0);
    rchk(ULP_ADDR_POWER_CTRL, 8'h60, "pc_ro");
    hw_found = 1'b1;
    cyc(6);
    idle_cnt = 0;
    ulp_link_model_inst.wr(ULP_ADDR_POWER_CTRL, 8'h01);
    cyc(1);
    chk8("fsm_idle", 8'h01, 8'(idle_cnt));
    hw_found = 1'b0;
    hw_sense = 1'b0;
    cyc(6);
    rchk(ULP_ADDR_POWER_CTRL, 8'he1, "pc_take");
    chk1("oe_take", 1'b1, pin_oe);
    chk1("sense_take", 1'b1, sense_en);
    ulp_link_model_inst.wr(ULP_ADDR_POWER_CTRL, 8'h01);
    cyc(2);
    chk1("oe_rel", 1'b0, pin_oe);
    chk1("sense_off", 1'b0, sense_en);
    pol = 1'b0;
    ulp_link_model_inst.wr(ULP_ADDR_POWER_CTRL, 8'h81);
    cyc(2);
    chk1("oe_man", 1'b1, pin_oe);
    chk1("pin_low", 1'b0, pin_o);
    ulp_link_model_inst.wr(ULP_ADDR_POWER_CTRL, 8'h11);
    cyc(2);
    chk1("wkpu_nosess", 1'b0, wkpu_en);
    st[ULP_EV_SVLD] = 1'b1;
    cyc(6);
    chk1("wkpu_sess", 1'b1, wkpu_en);
    sync_m = 1'b0;
    cyc(2);
    chk1("wkpu_nosync", 1'b0, wkpu_en);
    sync_m = 1'b1;
    ulp_link_model_inst.wr(ULP_ADDR_POWER_CTRL, 8'h09);
    alt_cnt = 0;
    b_sess = 1'b1;
    cyc(6);
    chk8("alt_rise_off", 8'h00, 8'(alt_cnt));
    b_sess = 1'b0;
    cyc(6);
    chk8("alt_drop", 8'h01, 8'(alt_cnt));
    ulp_link_model_inst.wr(ULP_ADDR_POWER_CTRL, 8'h05);
    alt_cnt = 0;
    b_sess = 1'b1;
    cyc(6);
    b_sess = 1'b0;
    cyc(6);
    chk8("alt_rise", 8'h01, 8'(alt_cnt));
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    final_report;
  end

  initial begin
    cyc(10);
    reset = 1'b0;
    cyc(8);
    t_reset;
    t_line;
    t_scratch;
    t_events;
    t_id;
    t_charger;
    final_report;
  end
endmodule
